// ===== core/button_menu_regs.svh
// constants of the front-panel menu: timing, defaults, register map
// assumes inclusion by bare name from the menu design files
`ifndef BUTTON_MENU_REGS_SVH
`define BUTTON_MENU_REGS_SVH

// long press of the set button, and the clock in kHz
`define MENU_HOLD_TIME_MS 5000
`define MENU_CLK_KHZ 200000

// threshold defaults in percent of full scale
`define MENU_UPPER_PCT 50
`define MENU_RESET_PCT 25
`define MENU_PCT_FULL 100

// menu size and encodings
`define MENU_PARAM_COUNT 14
`define MENU_LOCK_ON 1'b1
`define MENU_FN_STEP 2'h1

// register map, byte addresses
`define MENU_ADDR_CTRL 8'h00
`define MENU_ADDR_STATUS 8'h04
`define MENU_ADDR_PARAM_BASE 8'h40
`define MENU_ADDR_PARAM_LAST 8'h74
`define MENU_CTRL_DEFAULTS_BIT 0
`define MENU_STAT_LOCKED_BIT 0
`define MENU_STAT_OUT1_BIT 1
`define MENU_STAT_OUT2_BIT 2
`define MENU_STAT_STATE_LSB 4
`define MENU_STAT_ITEM_LSB 8

`endif

// ===== core/button_menu_pkg.sv
// types of the front-panel menu and its switching outputs
// assumes nothing beyond a SystemVerilog compiler
package button_menu_pkg;

    // menu entries, in the order the mode button steps through them
    typedef enum logic [3:0] {
        menu_unlocked_setting = 4'h0,
        out_one_function = 4'h1,
        out_one_upper_threshold = 4'h2,
        out_one_reset_threshold = 4'h3,
        out_one_window_high = 4'h4,
        out_one_window_low = 4'h5,
        out_two_function = 4'h6,
        out_two_upper_threshold = 4'h7,
        out_two_reset_threshold = 4'h8,
        out_two_window_high = 4'h9,
        out_two_window_low = 4'ha,
        analog_start_level = 4'hb,
        analog_end_level = 4'hc,
        extra_settings_submenu = 4'hd
    } param_id_t;

    typedef enum logic [1:0] {
        st_browse = 2'b00,
        st_show = 2'b01,
        st_edit = 2'b10,
        st_submenu = 2'b11
    } menu_state_t;

    typedef enum logic [1:0] {
        fn_hyst_open = 2'b00,
        fn_hyst_closed = 2'b01,
        fn_window_open = 2'b10,
        fn_window_closed = 2'b11
    } out_fn_t;

endpackage

// ===== core/switch_channel.sv
// one switching output: hysteresis or window, normally open or closed
// assumes thresholds and pressure in the same signed scale, one clock
`timescale 1ns/100ps
`default_nettype none
module switch_channel #(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic signed [W-1:0] pressure,
    input wire button_menu_pkg::out_fn_t fn,
    input wire logic signed [W-1:0] upper_th,
    input wire logic signed [W-1:0] reset_th,
    input wire logic signed [W-1:0] win_high,
    input wire logic signed [W-1:0] win_low,
    output logic sw_out
);
    logic hyst_on, next_hyst_on, next_sw_out, active;

    always_comb begin
        next_hyst_on = hyst_on;
        if (pressure >= upper_th) begin
            next_hyst_on = 1'b1;
        end else if (pressure <= reset_th) begin
            next_hyst_on = 1'b0;
        end
        case (fn)
            button_menu_pkg::fn_hyst_open,
            button_menu_pkg::fn_hyst_closed: active = next_hyst_on;
            default: active = (pressure >= win_low) && (pressure <= win_high);
        endcase
        // closed-contact selections invert the switching state
        if (fn == button_menu_pkg::fn_hyst_closed || fn == button_menu_pkg::fn_window_closed) begin
            next_sw_out = ~active;
        end else begin
            next_sw_out = active;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hyst_on <= 1'b0;
            sw_out <= 1'b0;
        end else begin
            hyst_on <= next_hyst_on;
            sw_out <= next_sw_out;
        end
    end

    generate
        if (W < 8) begin : g_bad_width
            $error("switch_channel: W must be at least 8");
        end
    endgenerate
endmodule // switch_channel
`default_nettype wire

// ===== core/button_menu.sv
// front-panel parameter menu with two configurable switching outputs
// assumes debounced, clock-synchronous button levels (high = pressed)
// and a signed pressure sample in the same scale as the thresholds
//
// The address map and strobed register access are this design's own decisions.
`include "button_menu_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module button_menu #(
    parameter int W = 16,
    parameter int FULL_SCALE = 1000,
    parameter int unsigned HOLD_CYCLES = `MENU_HOLD_TIME_MS * `MENU_CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic btn_mode,
    input wire logic btn_enter,
    input wire logic btn_set,
    input wire logic range_vacuum,
    input wire logic signed [W-1:0] pressure,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [31:0] bus_rdata,
    output logic [3:0] menu_item,
    output logic signed [W-1:0] display_value,
    output logic display_flash,
    output logic edit_active,
    output logic lock_shown,
    output logic submenu_active,
    output logic out_one,
    output logic out_two,
    output logic signed [W-1:0] analog_start_out,
    output logic signed [W-1:0] analog_end_out
);
    localparam int HCW = $clog2(HOLD_CYCLES + 1);
    localparam int NP = `MENU_PARAM_COUNT;
    localparam logic [HCW-1:0] HOLD_LAST = HCW'(HOLD_CYCLES - 1);
    localparam logic signed [W-1:0] FS_W = W'(FULL_SCALE);
    localparam logic signed [W-1:0] NEG_FS = -FS_W;
    localparam logic signed [W-1:0] DEF_UPPER =
        W'(FULL_SCALE * `MENU_UPPER_PCT / `MENU_PCT_FULL);
    localparam logic signed [W-1:0] DEF_LOWER =
        W'(FULL_SCALE * `MENU_RESET_PCT / `MENU_PCT_FULL);
    localparam logic signed [W-1:0] ONE_W = W'(1);

    generate
        if (HOLD_CYCLES < 2) begin : g_bad_hold
            $error("button_menu: HOLD_CYCLES must be at least 2");
        end
        if (FULL_SCALE < 4 || FULL_SCALE >= (1 << (W - 2))) begin : g_bad_scale
            $error("button_menu: FULL_SCALE does not fit W");
        end
    endgenerate

    // factory value of each entry; the start and end levels follow the range strap
    function automatic logic signed [W-1:0] default_of(input button_menu_pkg::param_id_t id,
                                                       input logic vac);
        case (id)
            button_menu_pkg::out_one_upper_threshold,
            button_menu_pkg::out_one_window_high,
            button_menu_pkg::out_two_upper_threshold,
            button_menu_pkg::out_two_window_high: default_of = DEF_UPPER;
            button_menu_pkg::out_one_reset_threshold,
            button_menu_pkg::out_one_window_low,
            button_menu_pkg::out_two_reset_threshold,
            button_menu_pkg::out_two_window_low: default_of = DEF_LOWER;
            button_menu_pkg::analog_start_level: default_of = vac ? NEG_FS : '0;
            button_menu_pkg::analog_end_level: default_of = vac ? '0 : FS_W;
            default: default_of = '0;
        endcase
    endfunction

    // one increment or decrement step of an entry
    function automatic logic signed [W-1:0] step_of(input button_menu_pkg::param_id_t id,
                                                    input logic signed [W-1:0] v,
                                                    input logic up);
        logic [1:0] fn;
        fn = v[1:0];
        case (id)
            button_menu_pkg::menu_unlocked_setting: begin
                step_of = (v == '0) ? ONE_W : '0;
            end
            button_menu_pkg::out_one_function,
            button_menu_pkg::out_two_function: begin
                fn = up ? fn + `MENU_FN_STEP : fn - `MENU_FN_STEP;
                step_of = {{(W - 2){1'b0}}, fn};
            end
            default: begin
                if (up) begin
                    step_of = (v < FS_W) ? v + ONE_W : v;
                end else begin
                    step_of = (v > NEG_FS) ? v - ONE_W : v;
                end
            end
        endcase
    endfunction

    logic mode_q, enter_q, set_q;
    logic mode_press, enter_press, set_press, set_release;
    logic locked, editable, item_is_sub;
    button_menu_pkg::menu_state_t state, next_state;
    button_menu_pkg::param_id_t item, next_item, item_after;
    logic [HCW-1:0] hold_cnt, next_hold_cnt;
    logic signed [W-1:0] param_q [0:NP-1];
    logic signed [W-1:0] next_param [0:NP-1];
    logic signed [W-1:0] edit_val, next_edit_val;
    logic load_def, next_load_def;
    logic [31:0] next_rdata;
    logic signed [W-1:0] next_display;
    logic ch_one, ch_two;

    // press and release edges
    always_comb begin
        mode_press = btn_mode && !mode_q;
        enter_press = btn_enter && !enter_q;
        set_press = btn_set && !set_q;
        set_release = !btn_set && set_q;
        locked = param_q[button_menu_pkg::menu_unlocked_setting][0] == `MENU_LOCK_ON;
        item_is_sub = item == button_menu_pkg::extra_settings_submenu;
        editable = !item_is_sub && (!locked || item == button_menu_pkg::menu_unlocked_setting);
        if (item_is_sub) begin
            item_after = button_menu_pkg::menu_unlocked_setting;
        end else begin
            item_after = button_menu_pkg::param_id_t'(item + 4'h1);
        end
    end

    // menu sequencing and parameter store
    always_comb begin
        next_state = state;
        next_item = item;
        next_hold_cnt = '0;
        next_edit_val = edit_val;
        next_load_def = 1'b0;
        for (int i = 0; i < NP; i++) begin
            next_param[i] = param_q[i];
        end
        case (state)
            button_menu_pkg::st_browse: begin
                if (mode_press) begin
                    next_item = item_after;
                end else if (btn_set) begin
                    if (hold_cnt == HOLD_LAST) begin
                        next_hold_cnt = hold_cnt;
                        if (editable) begin
                            next_state = button_menu_pkg::st_edit;
                            next_hold_cnt = '0;
                            next_edit_val = param_q[item];
                        end
                    end else begin
                        next_hold_cnt = hold_cnt + HCW'(1);
                    end
                end else if (set_release && hold_cnt != HOLD_LAST) begin
                    if (item_is_sub) begin
                        next_state = button_menu_pkg::st_submenu;
                    end else begin
                        next_state = button_menu_pkg::st_show;
                    end
                end
            end
            button_menu_pkg::st_show: begin
                if (mode_press) begin
                    next_state = button_menu_pkg::st_browse;
                    next_item = item_after;
                end else if (enter_press || set_press) begin
                    next_state = button_menu_pkg::st_browse;
                end
            end
            button_menu_pkg::st_edit: begin
                if (enter_press) begin
                    next_param[item] = edit_val;
                    next_state = button_menu_pkg::st_browse;
                end else if (set_press && !btn_mode) begin
                    next_edit_val = step_of(item, edit_val, 1'b1);
                end else if (mode_press && !btn_set) begin
                    next_edit_val = step_of(item, edit_val, 1'b0);
                end
            end
            default: begin
                if (mode_press) begin
                    next_state = button_menu_pkg::st_browse;
                    next_item = item_after;
                end
            end
        endcase
        if (load_def) begin
            for (int i = 0; i < NP; i++) begin
                next_param[i] = default_of(button_menu_pkg::param_id_t'(i), range_vacuum);
            end
        end
        if (bus_write && bus_addr == `MENU_ADDR_CTRL && bus_wdata[`MENU_CTRL_DEFAULTS_BIT]) begin
            next_load_def = 1'b1;
        end
    end

    // register read port, data valid only in the cycle after the strobe
    always_comb begin
        next_rdata = '0;
        if (bus_read) begin
            if (bus_addr == `MENU_ADDR_STATUS) begin
                next_rdata[`MENU_STAT_LOCKED_BIT] = locked;
                next_rdata[`MENU_STAT_OUT1_BIT] = out_one;
                next_rdata[`MENU_STAT_OUT2_BIT] = out_two;
                next_rdata[`MENU_STAT_STATE_LSB +: 2] = state;
                next_rdata[`MENU_STAT_ITEM_LSB +: 4] = item;
            end else if (bus_addr >= `MENU_ADDR_PARAM_BASE && bus_addr <= `MENU_ADDR_PARAM_LAST
                         && bus_addr[1:0] == 2'b00) begin
                next_rdata[W-1:0] = param_q[4'(bus_addr[7:2] - (`MENU_ADDR_PARAM_BASE >> 2))];
            end
        end
    end

    // display follows the edited copy in edit, the stored value otherwise
    always_comb begin
        if (next_state == button_menu_pkg::st_edit) begin
            next_display = next_edit_val;
        end else begin
            next_display = next_param[next_item];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 1'b0;
            enter_q <= 1'b0;
            set_q <= 1'b0;
            state <= button_menu_pkg::st_browse;
            item <= button_menu_pkg::menu_unlocked_setting;
            hold_cnt <= '0;
            edit_val <= '0;
            load_def <= 1'b1;
            for (int i = 0; i < NP; i++) begin
                param_q[i] <= '0;
            end
            bus_rdata <= '0;
            menu_item <= '0;
            display_value <= '0;
            display_flash <= 1'b0;
            edit_active <= 1'b0;
            lock_shown <= 1'b0;
            submenu_active <= 1'b0;
            out_one <= 1'b0;
            out_two <= 1'b0;
            analog_start_out <= '0;
            analog_end_out <= '0;
        end else begin
            mode_q <= btn_mode;
            enter_q <= btn_enter;
            set_q <= btn_set;
            state <= next_state;
            item <= next_item;
            hold_cnt <= next_hold_cnt;
            edit_val <= next_edit_val;
            load_def <= next_load_def;
            for (int i = 0; i < NP; i++) begin
                param_q[i] <= next_param[i];
            end
            bus_rdata <= next_rdata;
            menu_item <= next_item;
            display_value <= next_display;
            // flashing while set is held, stops once edit is entered
            display_flash <= next_state == button_menu_pkg::st_browse && btn_set;
            edit_active <= next_state == button_menu_pkg::st_edit;
            lock_shown <= next_param[button_menu_pkg::menu_unlocked_setting][0]
                == `MENU_LOCK_ON;
            submenu_active <= next_state == button_menu_pkg::st_submenu;
            out_one <= ch_one;
            out_two <= ch_two;
            analog_start_out <= param_q[button_menu_pkg::analog_start_level];
            analog_end_out <= param_q[button_menu_pkg::analog_end_level];
        end
    end

    switch_channel #(
        .W(W)
    ) u_out_one (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pressure(pressure),
        .fn(button_menu_pkg::out_fn_t'(param_q[button_menu_pkg::out_one_function][1:0])),
        .upper_th(param_q[button_menu_pkg::out_one_upper_threshold]),
        .reset_th(param_q[button_menu_pkg::out_one_reset_threshold]),
        .win_high(param_q[button_menu_pkg::out_one_window_high]),
        .win_low(param_q[button_menu_pkg::out_one_window_low]),
        .sw_out(ch_one)
    );

    switch_channel #(
        .W(W)
    ) u_out_two (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pressure(pressure),
        .fn(button_menu_pkg::out_fn_t'(param_q[button_menu_pkg::out_two_function][1:0])),
        .upper_th(param_q[button_menu_pkg::out_two_upper_threshold]),
        .reset_th(param_q[button_menu_pkg::out_two_reset_threshold]),
        .win_high(param_q[button_menu_pkg::out_two_window_high]),
        .win_low(param_q[button_menu_pkg::out_two_window_low]),
        .sw_out(ch_two)
    );
endmodule // button_menu
`default_nettype wire

// ===== verif/button_menu_checker.sv
// assertions on the menu ports: navigation, edit entry, lock, commit
// assumes binding onto button_menu, one clock, reset active low
`timescale 1ns/100ps
`default_nettype none
module button_menu_checker #(
    parameter int unsigned HOLD_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic btn_mode,
    input wire logic btn_enter,
    input wire logic btn_set,
    input wire logic bus_write,
    input wire logic [3:0] menu_item,
    input wire logic display_flash,
    input wire logic edit_active,
    input wire logic lock_shown,
    input wire logic submenu_active
);
    logic [31:0] hold_cnt;
    logic [31:0] next_hold_cnt;
    // cycles the set button has been held without a break
    always_comb begin
        next_hold_cnt = btn_set ? hold_cnt + 32'h1 : 32'h0;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt <= 32'h0;
        end else begin
            hold_cnt <= next_hold_cnt;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence long_hold_s;
        hold_cnt == HOLD_CYCLES + 2 && !lock_shown && menu_item != 4'hd;
    endsequence
    sequence step_cause_s;
        $past(btn_mode) || $past(btn_mode, 2) || $past(bus_write, 2) || $past(bus_write, 3);
    endsequence
    sequence enter_recent_s;
        $past(btn_enter) || $past(btn_enter, 2);
    endsequence
    a_edit_no_flash: assert property (edit_active |-> !display_flash)
        else $error("flash while editing");
    a_hold_enters_edit: assert property (long_hold_s |-> edit_active)
        else $error("long set hold did not enter edit");
    a_edit_needs_hold: assert property ($rose(edit_active) |-> hold_cnt >= HOLD_CYCLES - 1)
        else $error("edit entered on a short press");
    a_flash_needs_set: assert property (display_flash |-> $past(btn_set) || $past(btn_set, 2))
        else $error("flash without set held");
    a_lock_edit_item: assert property ($rose(edit_active) && $past(lock_shown) |-> menu_item == 4'h0)
        else $error("edit entered while locked");
    a_item_steps: assert property ($changed(menu_item) |-> step_cause_s ##0
        (menu_item == (($past(menu_item) == 4'hd) ? 4'h0 : $past(menu_item) + 4'h1)))
        else $error("menu item did not step by one");
    a_commit_on_enter: assert property ($fell(edit_active) |-> enter_recent_s)
        else $error("edit left without enter");
    a_submenu_entry: assert property ($rose(submenu_active) |-> menu_item == 4'hd)
        else $error("submenu entered from wrong item");
    a_lock_needs_enter: assert property ($rose(lock_shown) |-> enter_recent_s)
        else $error("lock set without enter");
endmodule // button_menu_checker

bind button_menu button_menu_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_button_menu_checker (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .btn_mode(btn_mode),
    .btn_enter(btn_enter),
    .btn_set(btn_set),
    .bus_write(bus_write),
    .menu_item(menu_item),
    .display_flash(display_flash),
    .edit_active(edit_active),
    .lock_shown(lock_shown),
    .submenu_active(submenu_active)
);
`default_nettype wire

// ===== verif/button_operator.sv
// operator at the front panel: presses and holds the three buttons
// assumes tasks are called from the bench, button levels high = pressed
`timescale 1ns/100ps
`default_nettype none
module button_operator (
    input wire logic sys_clk,
    output logic btn_mode,
    output logic btn_enter,
    output logic btn_set
);
    initial begin
        btn_mode = 1'b0;
        btn_enter = 1'b0;
        btn_set = 1'b0;
    end
    // 0 mode/down, 1 enter, 2 set/up
    task automatic push(input int b, input logic v);
        @(posedge sys_clk);
        case (b)
            0: btn_mode <= v;
            1: btn_enter <= v;
            default: btn_set <= v;
        endcase
    endtask
    // press, hold n+1 cycles, release, then leave a gap so the next press is an edge
    task automatic tap(input int b, input int n);
        push(b, 1'b1);
        repeat (n) @(posedge sys_clk);
        push(b, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
endmodule // button_operator
`default_nettype wire

// ===== verif/button_menu_switch_outputs_test.sv
// self-checking bench of the front-panel menu and its switching outputs
// assumes the operator model for the buttons and a short set-hold count
`include "button_menu_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module button_menu_switch_outputs_test;
    localparam int W = 16;
    localparam int FS = 1000;
    localparam int unsigned HOLD = 8;
    localparam int HI = FS * `MENU_UPPER_PCT / `MENU_PCT_FULL;
    localparam int LO = FS * `MENU_RESET_PCT / `MENU_PCT_FULL;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic btn_mode, btn_enter, btn_set;
    logic range_vacuum = 1'b0;
    logic signed [W-1:0] pressure = '0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [31:0] bus_rdata;
    logic [3:0] menu_item;
    logic signed [W-1:0] display_value, analog_start_out, analog_end_out;
    logic display_flash, edit_active, lock_shown, submenu_active, out_one, out_two;
    int mismatches = 0;
    int samples_checked = 0;
    logic [31:0] lfsr = 32'h6a904f5d;
    logic hs = 1'b0;
    int p;
    int corner[4] = '{HI, HI - 1, LO, LO + 1};

    always #2.5 sys_clk = ~sys_clk;

    button_operator u_button_operator (
        .sys_clk(sys_clk),
        .btn_mode(btn_mode),
        .btn_enter(btn_enter),
        .btn_set(btn_set)
    );
    button_menu #(.W(W), .FULL_SCALE(FS), .HOLD_CYCLES(HOLD)) u_button_menu (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .btn_mode(btn_mode),
        .btn_enter(btn_enter),
        .btn_set(btn_set),
        .range_vacuum(range_vacuum),
        .pressure(pressure),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_write(bus_write),
        .bus_read(bus_read),
        .bus_rdata(bus_rdata),
        .menu_item(menu_item),
        .display_value(display_value),
        .display_flash(display_flash),
        .edit_active(edit_active),
        .lock_shown(lock_shown),
        .submenu_active(submenu_active),
        .out_one(out_one),
        .out_two(out_two),
        .analog_start_out(analog_start_out),
        .analog_end_out(analog_end_out)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_param(input int i, input logic vac);
        logic [W-1:0] v;
        case (i)
            2, 4, 7, 9: v = W'(HI);
            3, 5, 8, 10: v = W'(LO);
            11: v = vac ? W'(-FS) : '0;
            12: v = vac ? '0 : W'(FS);
            default: v = '0;
        endcase
        return {16'h0000, v};
    endfunction
    function automatic logic exp_out(input int fn, input int pr, input logic h);
        logic win;
        win = pr >= LO && pr <= HI;
        return (fn < 2) ? (h ^ (fn == 1)) : (win ^ (fn == 3));
    endfunction

    task automatic chk_val(input logic [31:0] got, input logic [31:0] e);
        samples_checked++;
        if (got !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t value %h expected %h", $time, got, e);
        end
    endtask
    task automatic chk_flag(input logic got, input logic e);
        samples_checked++;
        if (got !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t flag %b expected %b", $time, got, e);
        end
    endtask
    task automatic bus_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        bus_read <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_read <= 1'b0;
        #1;
        chk_val(bus_rdata, e);
    endtask
    task automatic goto(input logic [3:0] item);
        int n;
        n = 0;
        while (menu_item !== item && n < 20) begin
            u_button_operator.tap(0, 2);
            n++;
        end
    endtask
    task automatic restore();
        goto(4'hd);
        @(posedge sys_clk);
        bus_write <= 1'b1;
        bus_addr <= `MENU_ADDR_CTRL;
        bus_wdata <= 32'h1;
        @(posedge sys_clk);
        bus_write <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    // long set hold: flashing first, then edit unless refused
    task automatic hold_edit(input logic [3:0] item, input logic ok);
        goto(item);
        u_button_operator.push(2, 1'b1);
        repeat (4) @(posedge sys_clk);
        #1;
        chk_flag(edit_active, 1'b0);
        chk_flag(display_flash, 1'b1);
        repeat (HOLD) @(posedge sys_clk);
        #1;
        chk_flag(edit_active, ok);
        if (ok) chk_flag(display_flash, 1'b0);
        u_button_operator.push(2, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        for (int i = 0; i < 13; i++) begin
            bus_chk(8'h40 + 8'(4 * i), exp_param(i, 1'b0));
        end
        chk_val({16'h0, analog_end_out}, exp_param(12, 1'b0));
        bus_chk(8'h08, 32'h0);
        bus_chk(`MENU_ADDR_STATUS, 32'h0);
        bus_chk(8'h41, 32'h0);
        chk_val({28'h0, menu_item}, 32'h0);
        for (int i = 1; i <= 14; i++) begin
            u_button_operator.tap(0, 2);
            chk_val({28'h0, menu_item}, 32'(i % 14));
        end
        goto(4'h2);
        u_button_operator.tap(2, 2);
        chk_flag(edit_active, 1'b0);
        chk_val({16'h0, display_value}, exp_param(2, 1'b0));
        u_button_operator.tap(1, 2);
        hold_edit(4'h2, 1'b1);
        u_button_operator.tap(2, 2);
        u_button_operator.tap(2, 2);
        u_button_operator.tap(0, 2);
        chk_val({16'h0, display_value}, 32'(HI + 1));
        bus_chk(8'h48, 32'(HI));
        u_button_operator.tap(1, 2);
        chk_flag(edit_active, 1'b0);
        bus_chk(8'h48, 32'(HI + 1));
        @(posedge sys_clk);
        range_vacuum <= 1'b1;
        restore();
        bus_chk(8'h6c, exp_param(11, 1'b1));
        bus_chk(8'h70, exp_param(12, 1'b1));
        chk_val({16'h0, analog_start_out}, exp_param(11, 1'b1));
        bus_chk(8'h48, 32'(HI));
        @(posedge sys_clk);
        range_vacuum <= 1'b0;
        restore();
        hold_edit(4'h0, 1'b1);
        u_button_operator.tap(2, 2);
        u_button_operator.tap(1, 2);
        chk_flag(lock_shown, 1'b1);
        bus_chk(8'h40, 32'h1);
        bus_chk(`MENU_ADDR_STATUS, 32'h1);
        hold_edit(4'h2, 1'b0);
        goto(4'hd);
        u_button_operator.tap(2, 2);
        chk_flag(submenu_active, 1'b1);
        u_button_operator.tap(0, 2);
        restore();
        chk_flag(lock_shown, 1'b0);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) begin
                hold_edit(4'h1, 1'b1);
                u_button_operator.tap(2, 2);
                u_button_operator.tap(1, 2);
                hold_edit(4'h6, 1'b1);
                u_button_operator.tap(2, 2);
                u_button_operator.tap(1, 2);
            end
            @(posedge sys_clk);
            pressure <= '0;
            hs = 1'b0;
            for (int j = 0; j < 16; j++) begin
                p = (j < 4) ? corner[j] : int'(lfsr % 32'd1201) - 100;
                lfsr = lfsr_next(lfsr);
                @(posedge sys_clk);
                pressure <= W'(p);
                repeat (4) @(posedge sys_clk);
                #1;
                if (p >= HI) hs = 1'b1;
                else if (p <= LO) hs = 1'b0;
                chk_flag(out_one, exp_out(k, p, hs));
                chk_flag(out_two, exp_out(k, p, hs));
            end
        end
        tally_and_finish();
    end
endmodule // button_menu_switch_outputs_test
`default_nettype wire
